// ---- verilog/imsum_top.sv ----
// imsum_top: interrupt masks, top and regulator-group summaries and the
// active-low interrupt output.
// assumes the register port and source inputs come from logic on clock;
// only resetn is asynchronous and is synchronised here.
`timescale 1ns/10ps

module imsum_top
    import imsum_pkg::*;
#(
    parameter int FLAG_WIDTH = 8
) (
    input wire logic clock, // 25 MHz block clock
    input wire logic resetn, // asynchronous reset, active low
    input wire logic [7:0] reg_addr, // register offset
    input wire logic [7:0] reg_wdata, // write data
    input wire logic reg_wr, // write strobe, one cycle
    input wire logic reg_rd, // read strobe, one cycle
    output logic [7:0] reg_rdata_q, // read data, one cycle after reg_rd
    input wire logic [7:0] config_readback_mask, // config memory default
    input wire logic [7:0] config_monitor_mask, // config memory default
    input wire logic soc_reset_out_readback_event, // source detector
    input wire logic enable_drive_readback_event, // source detector
    input wire logic monitor_mcu_reset_event, // source detector
    input wire logic monitor_mcu_failure_event, // source detector
    input wire logic monitor_mcu_pin_event, // source detector
    output logic soc_reset_out_readback_flag_set_q, // unmasked event pulse
    output logic enable_drive_readback_flag_set_q, // unmasked event pulse
    output logic monitor_mcu_reset_flag_set_q, // unmasked event pulse
    output logic monitor_mcu_failure_flag_set_q, // unmasked event pulse
    output logic monitor_mcu_pin_flag_set_q, // unmasked event pulse
    input wire logic [FLAG_WIDTH-1:0] state_machine_error_flags, // lower flags
    input wire logic [FLAG_WIDTH-1:0] severe_error_flags, // lower flags
    input wire logic [FLAG_WIDTH-1:0] moderate_error_flags, // lower flags
    input wire logic [FLAG_WIDTH-1:0] misc_flags, // lower flags
    input wire logic [FLAG_WIDTH-1:0] power_up_flags, // lower flags
    input wire logic [FLAG_WIDTH-1:0] gpio_flags, // lower flags
    input wire logic [FLAG_WIDTH-1:0] voltage_monitor_flags, // lower flags
    input wire logic [7:0] regulators_one_two_events, // regulator events
    input wire logic [7:0] regulators_three_four_events, // regulator events
    output logic interrupt_output_low_q // interrupt pin, active low
);

    // ==========================================================
    // elaboration check
    if (FLAG_WIDTH < 1 || FLAG_WIDTH > 8) begin : g_width_check
        $error("imsum_top: FLAG_WIDTH must be 1 to 8");
    end

    // ==========================================================
    // reset synchroniser: release is clocked, assertion is immediate
    logic rst_meta_q;
    logic rst_n;

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            rst_meta_q <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n <= rst_meta_q;
        end
    end

    // ==========================================================
    // register port decode
    logic wr_readback_mask;
    logic wr_monitor_mask;
    logic wr_reg12;
    logic wr_reg34;

    // summary offsets decode to nothing on write
    assign wr_readback_mask = reg_wr && (reg_addr == ADDR_READBACK_MASK);
    assign wr_monitor_mask = reg_wr && (reg_addr == ADDR_MONITOR_MASK);
    assign wr_reg12 = reg_wr && (reg_addr == ADDR_REG12_FLAGS);
    assign wr_reg34 = reg_wr && (reg_addr == ADDR_REG34_FLAGS);

    // ==========================================================
    // mask registers
    logic loaded_q;
    logic [7:0] readback_mask_q;
    logic [7:0] readback_mask_d;
    logic [7:0] monitor_mask_q;
    logic [7:0] monitor_mask_d;

    // first cycle after release takes the config defaults; a write in
    // that same cycle loses, since the defaults are not yet in place
    assign readback_mask_d = !loaded_q ? (config_readback_mask & RB_WRITABLE)
        : wr_readback_mask ? (reg_wdata & RB_WRITABLE) : readback_mask_q;
    assign monitor_mask_d = !loaded_q ? (config_monitor_mask & MON_WRITABLE)
        : wr_monitor_mask ? (reg_wdata & MON_WRITABLE) : monitor_mask_q;

    // mask storage
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            loaded_q <= 1'b0;
            readback_mask_q <= REG_RESET;
            monitor_mask_q <= REG_RESET;
        end else begin
            loaded_q <= 1'b1;
            readback_mask_q <= readback_mask_d;
            monitor_mask_q <= monitor_mask_d;
        end
    end

    // ==========================================================
    // source gating: a set mask bit stops the event from raising a flag
    logic soc_raise;
    logic drive_raise;
    logic mcu_reset_raise;
    logic mcu_fail_raise;
    logic mcu_pin_raise;

    assign soc_raise = soc_reset_out_readback_event
        && !readback_mask_q[RB_SOC_RESET_BIT];
    assign drive_raise = enable_drive_readback_event
        && !readback_mask_q[RB_ENABLE_DRIVE_BIT];
    assign mcu_reset_raise = monitor_mcu_reset_event
        && !monitor_mask_q[MON_MCU_RESET_BIT];
    assign mcu_fail_raise = monitor_mcu_failure_event
        && !monitor_mask_q[MON_MCU_FAIL_BIT];
    assign mcu_pin_raise = monitor_mcu_pin_event
        && !monitor_mask_q[MON_MCU_PIN_BIT];

    // raise pulses registered so every output leaves a flip-flop
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            soc_reset_out_readback_flag_set_q <= 1'b0;
            enable_drive_readback_flag_set_q <= 1'b0;
            monitor_mcu_reset_flag_set_q <= 1'b0;
            monitor_mcu_failure_flag_set_q <= 1'b0;
            monitor_mcu_pin_flag_set_q <= 1'b0;
        end else begin
            soc_reset_out_readback_flag_set_q <= soc_raise;
            enable_drive_readback_flag_set_q <= drive_raise;
            monitor_mcu_reset_flag_set_q <= mcu_reset_raise;
            monitor_mcu_failure_flag_set_q <= mcu_fail_raise;
            monitor_mcu_pin_flag_set_q <= mcu_pin_raise;
        end
    end

    // ==========================================================
    // regulator flag registers, cleared by writing one
    logic [7:0] regulators_one_two_flags;
    logic [7:0] regulators_three_four_flags;

    imsum_flag_reg #(
        .WIDTH(8)
    ) u_reg12_flags (
        .clock(clock),
        .rst_n(rst_n),
        .set_pulse(regulators_one_two_events),
        .clear_wr(wr_reg12),
        .clear_data(reg_wdata),
        .flags_q(regulators_one_two_flags)
    );

    imsum_flag_reg #(
        .WIDTH(8)
    ) u_reg34_flags (
        .clock(clock),
        .rst_n(rst_n),
        .set_pulse(regulators_three_four_events),
        .clear_wr(wr_reg34),
        .clear_data(reg_wdata),
        .flags_q(regulators_three_four_flags)
    );

    // ==========================================================
    // summaries: registered reductions, so they fall one cycle after their inputs clear
    logic [7:0] group_summary_q;
    logic [7:0] group_summary_d;
    logic [7:0] top_summary_q;
    logic [7:0] top_summary_d;

    assign group_summary_d[7:2] = '0;
    assign group_summary_d[GRP_REG34_BIT] = |regulators_three_four_flags;
    assign group_summary_d[GRP_REG12_BIT] = |regulators_one_two_flags;

    // top bit 0 follows the group register, so it trails by one cycle
    assign top_summary_d[TOP_FSM_BIT] = |state_machine_error_flags;
    assign top_summary_d[TOP_SEVERE_BIT] = |severe_error_flags;
    assign top_summary_d[TOP_MODERATE_BIT] = |moderate_error_flags;
    assign top_summary_d[TOP_MISC_BIT] = |misc_flags;
    assign top_summary_d[TOP_POWER_UP_BIT] = |power_up_flags;
    assign top_summary_d[TOP_GPIO_BIT] = |gpio_flags;
    assign top_summary_d[TOP_VMON_BIT] = |voltage_monitor_flags;
    assign top_summary_d[TOP_GROUP_BIT] = |group_summary_q;

    // summary storage; no write path reaches these
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            group_summary_q <= REG_RESET;
            top_summary_q <= REG_RESET;
        end else begin
            group_summary_q <= group_summary_d;
            top_summary_q <= top_summary_d;
        end
    end

    // ==========================================================
    // interrupt pin tracks the same next value as the top register
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            interrupt_output_low_q <= 1'b1;
        end else begin
            interrupt_output_low_q <= ~|top_summary_d;
        end
    end

    // ==========================================================
    // read mux; unmapped offsets answer zero
    logic [7:0] read_mux;

    assign read_mux =
        (reg_addr == ADDR_READBACK_MASK) ? readback_mask_q :
        (reg_addr == ADDR_MONITOR_MASK) ? monitor_mask_q :
        (reg_addr == ADDR_TOP_SUMMARY) ? top_summary_q :
        (reg_addr == ADDR_GROUP_SUMMARY) ? group_summary_q :
        (reg_addr == ADDR_REG12_FLAGS) ? regulators_one_two_flags :
        (reg_addr == ADDR_REG34_FLAGS) ? regulators_three_four_flags :
        READ_UNMAPPED;

    // read data holds until the next read
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata_q <= REG_RESET;
        end else if (reg_rd) begin
            reg_rdata_q <= read_mux;
        end
    end

    // ==========================================================
    // checks
    property p_soc_masked;
        @(posedge clock) disable iff (!rst_n)
        (soc_reset_out_readback_event && readback_mask_q[RB_SOC_RESET_BIT])
            |=> !soc_reset_out_readback_flag_set_q;
    endproperty
    a_soc_masked: assert property (p_soc_masked)
        else $error("masked soc readback event raised");

    property p_drive_pass;
        @(posedge clock) disable iff (!rst_n)
        (enable_drive_readback_event && !readback_mask_q[RB_ENABLE_DRIVE_BIT])
            |=> enable_drive_readback_flag_set_q;
    endproperty
    a_drive_pass: assert property (p_drive_pass)
        else $error("unmasked drive readback event dropped");

    property p_mcu_reset_gate;
        @(posedge clock) disable iff (!rst_n)
        ##1 monitor_mcu_reset_flag_set_q == ($past(monitor_mcu_reset_event)
            && !$past(monitor_mask_q[MON_MCU_RESET_BIT]));
    endproperty
    a_mcu_reset_gate: assert property (p_mcu_reset_gate)
        else $error("mcu reset gating wrong");

    property p_mcu_fail_gate;
        @(posedge clock) disable iff (!rst_n)
        (monitor_mcu_failure_event && monitor_mask_q[MON_MCU_FAIL_BIT])
            |=> !monitor_mcu_failure_flag_set_q;
    endproperty
    a_mcu_fail_gate: assert property (p_mcu_fail_gate)
        else $error("masked mcu failure raised");

    property p_mcu_pin_gate;
        @(posedge clock) disable iff (!rst_n)
        (monitor_mcu_pin_event && !monitor_mask_q[MON_MCU_PIN_BIT])
            |=> monitor_mcu_pin_flag_set_q;
    endproperty
    a_mcu_pin_gate: assert property (p_mcu_pin_gate)
        else $error("unmasked mcu pin event dropped");

    property p_reserved_zero;
        @(posedge clock) disable iff (!rst_n)
        ((readback_mask_q & ~RB_WRITABLE) == '0)
            && ((monitor_mask_q & ~MON_WRITABLE) == '0)
            && (group_summary_q[7:2] == '0);
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("reserved bit set");

    property p_fsm_summary;
        @(posedge clock) disable iff (!rst_n)
        (state_machine_error_flags != '0) |=> top_summary_q[TOP_FSM_BIT];
    endproperty
    a_fsm_summary: assert property (p_fsm_summary)
        else $error("fsm summary not set");

    property p_severe_clear;
        @(posedge clock) disable iff (!rst_n)
        (severe_error_flags == '0) |=> !top_summary_q[TOP_SEVERE_BIT];
    endproperty
    a_severe_clear: assert property (p_severe_clear)
        else $error("severe summary stuck");

    property p_moderate_summary;
        @(posedge clock) disable iff (!rst_n)
        (moderate_error_flags != '0) |=> top_summary_q[TOP_MODERATE_BIT];
    endproperty
    a_moderate_summary: assert property (p_moderate_summary)
        else $error("moderate summary not set");

    property p_misc_clear;
        @(posedge clock) disable iff (!rst_n)
        (misc_flags == '0) |=> !top_summary_q[TOP_MISC_BIT];
    endproperty
    a_misc_clear: assert property (p_misc_clear)
        else $error("misc summary stuck");

    property p_power_up_summary;
        @(posedge clock) disable iff (!rst_n)
        (power_up_flags != '0) |=> top_summary_q[TOP_POWER_UP_BIT];
    endproperty
    a_power_up_summary: assert property (p_power_up_summary)
        else $error("power-up summary not set");

    property p_gpio_clear;
        @(posedge clock) disable iff (!rst_n)
        (gpio_flags == '0) |=> !top_summary_q[TOP_GPIO_BIT];
    endproperty
    a_gpio_clear: assert property (p_gpio_clear)
        else $error("gpio summary stuck");

    property p_vmon_summary;
        @(posedge clock) disable iff (!rst_n)
        (voltage_monitor_flags != '0) |=> top_summary_q[TOP_VMON_BIT];
    endproperty
    a_vmon_summary: assert property (p_vmon_summary)
        else $error("voltage monitor summary not set");

    property p_group_chain;
        @(posedge clock) disable iff (!rst_n)
        (regulators_three_four_events != '0) ##1 !wr_reg34
            |=> group_summary_q[GRP_REG34_BIT] ##1 top_summary_q[TOP_GROUP_BIT];
    endproperty
    a_group_chain: assert property (p_group_chain)
        else $error("regulator summary chain broken");

    property p_irq_pin;
        @(posedge clock) disable iff (!rst_n)
        ##1 interrupt_output_low_q == (top_summary_q == '0);
    endproperty
    a_irq_pin: assert property (p_irq_pin)
        else $error("interrupt pin disagrees with summary");

    property p_summary_ro;
        @(posedge clock) disable iff (!rst_n)
        (reg_wr && reg_addr == ADDR_TOP_SUMMARY && regulators_one_two_events == '0)
            |=> $stable(regulators_one_two_flags);
    endproperty
    a_summary_ro: assert property (p_summary_ro)
        else $error("summary write disturbed flags");

endmodule : imsum_top

// ---- verilog/imsum_pkg.sv ----
// imsum_pkg: register map, field positions and reset values for the
// interrupt mask and summary block.
// assumes an 8-bit register port driven by the serial interface decoder.
//
// Behaviour
// - readback mask bit 3 set blocks the SoC reset-output readback interrupt
// - readback mask bit 0 set blocks the enable-drive readback interrupt
// - monitor mask bit 5 set suppresses the monitor MCU reset interrupt
// - monitor mask bit 4 set suppresses the MCU monitor failure interrupt
// - monitor mask bit 3 set suppresses the MCU monitor pin error interrupt
// - mask defaults load from config memory at power-up; reserved bits read zero
// - top bit 7 shows pending state-machine error flags, clears when all zero
// - top bit 6 shows pending severe error flags, clears when all zero
// - top bit 5 shows pending moderate error flags, clears when all zero
// - top bit 4 shows pending miscellaneous flags, clears when all zero
// - top bit 3 shows pending power-up flags, clears when all zero
// - top bit 2 shows pending general-purpose pin flags, clears when all zero
// - top bit 1 shows pending voltage monitor flags, clears when all zero
// - top bit 0 shows any regulator-group summary bit, clears when all zero
// - group bit 1 shows pending regulator three/four flags
// - group bit 0 shows pending regulator one/two flags; bits 7:2 read zero
// - source flags latch on events; host clears by writing one

package imsum_pkg;

    // ==========================================================
    // register offsets
    localparam logic [7:0] ADDR_READBACK_MASK = 8'h58;
    localparam logic [7:0] ADDR_MONITOR_MASK = 8'h59;
    localparam logic [7:0] ADDR_TOP_SUMMARY = 8'h5A;
    localparam logic [7:0] ADDR_GROUP_SUMMARY = 8'h5B;
    localparam logic [7:0] ADDR_REG12_FLAGS = 8'h5C;
    localparam logic [7:0] ADDR_REG34_FLAGS = 8'h5D;

    // ==========================================================
    // field positions
    localparam int RB_SOC_RESET_BIT = 3;
    localparam int RB_ENABLE_DRIVE_BIT = 0;
    localparam int MON_MCU_RESET_BIT = 5;
    localparam int MON_MCU_FAIL_BIT = 4;
    localparam int MON_MCU_PIN_BIT = 3;
    localparam int TOP_FSM_BIT = 7;
    localparam int TOP_SEVERE_BIT = 6;
    localparam int TOP_MODERATE_BIT = 5;
    localparam int TOP_MISC_BIT = 4;
    localparam int TOP_POWER_UP_BIT = 3;
    localparam int TOP_GPIO_BIT = 2;
    localparam int TOP_VMON_BIT = 1;
    localparam int TOP_GROUP_BIT = 0;
    localparam int GRP_REG34_BIT = 1;
    localparam int GRP_REG12_BIT = 0;

    // ==========================================================
    // writable bits and reset values
    localparam logic [7:0] RB_WRITABLE = 8'h09;
    localparam logic [7:0] MON_WRITABLE = 8'h38;
    localparam logic [7:0] GRP_USED = 8'h03;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;

endpackage : imsum_pkg

// ---- verilog/imsum_flag_reg.sv ----
// imsum_flag_reg: latched source flags, cleared by writing one.
// assumes set and clear strobes come from logic on the same clock.
`timescale 1ns/10ps

module imsum_flag_reg
    import imsum_pkg::*;
#(
    parameter int WIDTH = 8
) (
    input wire logic clock, // block clock
    input wire logic rst_n, // synchronised reset, active low
    input wire logic [WIDTH-1:0] set_pulse, // source events
    input wire logic clear_wr, // write strobe to this register
    input wire logic [WIDTH-1:0] clear_data, // ones clear flags
    output logic [WIDTH-1:0] flags_q // latched flags
);

    // ==========================================================
    // elaboration check
    if (WIDTH < 1 || WIDTH > 8) begin : g_width_check
        $error("imsum_flag_reg: WIDTH must be 1 to 8");
    end

    // ==========================================================
    // next value: an event in the clearing cycle is kept
    logic [WIDTH-1:0] clear_mask;
    logic [WIDTH-1:0] flags_d;

    assign clear_mask = clear_wr ? clear_data : '0;
    assign flags_d = (flags_q & ~clear_mask) | set_pulse;

    // flag storage
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            flags_q <= '0;
        end else begin
            flags_q <= flags_d;
        end
    end

    // ==========================================================
    // checks
    property p_set_wins;
        @(posedge clock) disable iff (!rst_n)
        (set_pulse != '0) |=> ((flags_q & $past(set_pulse)) == $past(set_pulse));
    endproperty
    a_set_wins: assert property (p_set_wins)
        else $error("flag event lost");

    property p_w1c;
        @(posedge clock) disable iff (!rst_n)
        (clear_wr && set_pulse == '0)
            |=> (flags_q == ($past(flags_q) & ~$past(clear_data)));
    endproperty
    a_w1c: assert property (p_w1c)
        else $error("write-one clear wrong");

endmodule : imsum_flag_reg

// ---- test/imsum_host_model.sv ----
// imsum_host_model: host side of the register port, byte writes and reads.
// assumes read data is held on reg_rdata_q from one cycle after the request.
`timescale 1ns/10ps

module imsum_host_model (
    input wire logic clock, // block clock
    output logic [7:0] reg_addr, // register offset
    output logic [7:0] reg_wdata, // write data
    output logic reg_wr, // write strobe
    output logic reg_rd, // read strobe
    input wire logic [7:0] reg_rdata_q // read data
);
    // ==========================================================
    // idle bus shows inverted leftovers, so a stale value never looks valid
    initial begin
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end

    // one-cycle write strobe; flags are cleared only by ones in the data
    task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
        @(negedge clock);
        reg_addr = addr;
        reg_wdata = data;
        reg_wr = 1'b1;
        @(negedge clock);
        reg_wr = 1'b0;
        reg_addr = ~addr;
        reg_wdata = ~data;
    endtask : write_reg

    // one-cycle read strobe, data taken once it has settled
    task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
        @(negedge clock);
        reg_addr = addr;
        reg_rd = 1'b1;
        @(negedge clock);
        reg_rd = 1'b0;
        reg_addr = ~addr;
        @(negedge clock);
        data = reg_rdata_q;
    endtask : read_reg
endmodule : imsum_host_model

// ---- test/imsum_testbench.sv ----
// testbench: self-checking bench for imsum_top.
// assumes the host model drives the register port; inputs change on falling edges.
`timescale 1ns/10ps

module testbench;
    import imsum_pkg::*;
    logic clock = 1'b0;
    logic resetn = 1'b0;
    wire logic [7:0] reg_addr;
    wire logic [7:0] reg_wdata;
    wire logic reg_wr;
    wire logic reg_rd;
    logic [7:0] reg_rdata_q;
    logic [4:0] ev = 5'h00;
    wire logic [4:0] set_q;
    logic [7:0] flags [7] = '{default: 8'h00};
    logic [7:0] r_ev [2] = '{default: 8'h00};
    logic interrupt_output_low_q;
    int error_cnt = 0;
    int checked = 0;

    // ==========================================================
    // 25 MHz clock
    always #20 clock = ~clock;

    imsum_host_model host_model (.clock(clock), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q));

    imsum_top DUT (.clock(clock), .resetn(resetn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
        .config_readback_mask(8'hFF), .config_monitor_mask(8'hD6),
        .soc_reset_out_readback_event(ev[0]), .enable_drive_readback_event(ev[1]),
        .monitor_mcu_reset_event(ev[2]), .monitor_mcu_failure_event(ev[3]),
        .monitor_mcu_pin_event(ev[4]),
        .soc_reset_out_readback_flag_set_q(set_q[0]),
        .enable_drive_readback_flag_set_q(set_q[1]),
        .monitor_mcu_reset_flag_set_q(set_q[2]), .monitor_mcu_failure_flag_set_q(set_q[3]),
        .monitor_mcu_pin_flag_set_q(set_q[4]),
        .state_machine_error_flags(flags[0]), .severe_error_flags(flags[1]),
        .moderate_error_flags(flags[2]), .misc_flags(flags[3]), .power_up_flags(flags[4]),
        .gpio_flags(flags[5]), .voltage_monitor_flags(flags[6]),
        .regulators_one_two_events(r_ev[0]), .regulators_three_four_events(r_ev[1]),
        .interrupt_output_low_q(interrupt_output_low_q));

    // ==========================================================
    // shared comparison and closing report
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic print_verdict();
        $display("errors %0d checks %0d", error_cnt, checked);
        if (error_cnt == 0 && checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : print_verdict

    // ==========================================================
    // defaults, reserved bits, group summary reset value and unmapped places
    task automatic sc_registers();
        logic [7:0] d;
        host_model.read_reg(ADDR_READBACK_MASK, d);
        chk(d, 8'h09);
        host_model.read_reg(ADDR_MONITOR_MASK, d);
        chk(d, 8'h10);
        host_model.read_reg(ADDR_GROUP_SUMMARY, d);
        chk(d, 8'h00);
        host_model.write_reg(ADDR_READBACK_MASK, 8'hF6);
        host_model.write_reg(ADDR_MONITOR_MASK, 8'hFF);
        host_model.write_reg(8'h60, 8'hFF);
        host_model.read_reg(ADDR_READBACK_MASK, d);
        chk(d, 8'h00);
        host_model.read_reg(ADDR_MONITOR_MASK, d);
        chk(d, 8'h38);
        host_model.read_reg(8'h60, d);
        chk(d, 8'h00);
    endtask : sc_registers

    // each mask bit alone suppresses exactly its own source
    task automatic sc_events();
        logic [7:0] rbm [6] = '{8'h08, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00};
        logic [7:0] mnm [6] = '{8'h00, 8'h00, 8'h20, 8'h10, 8'h08, 8'h00};
        for (int i = 0; i < 6; i++) begin
            host_model.write_reg(ADDR_READBACK_MASK, rbm[i]);
            host_model.write_reg(ADDR_MONITOR_MASK, mnm[i]);
            @(negedge clock);
            ev = 5'h1F;
            @(negedge clock);
            ev = 5'h00;
            chk({3'b000, set_q}, 8'h1F & ~(8'h01 << i));
            @(negedge clock);
            chk({3'b000, set_q}, 8'h00);
        end
    endtask : sc_events

    // lower flag registers drive top bits 7..1 and the pin
    task automatic sc_summary();
        logic [7:0] d;
        for (int i = 0; i < 7; i++) begin
            @(negedge clock);
            flags[i] = 8'h80 >> i;
            repeat (2) @(negedge clock);
            chk({7'h00, interrupt_output_low_q}, 8'h00);
            host_model.read_reg(ADDR_TOP_SUMMARY, d);
            chk(d, 8'h80 >> i);
            flags[i] = 8'h00;
            repeat (2) @(negedge clock);
            chk({7'h00, interrupt_output_low_q}, 8'h01);
            host_model.read_reg(ADDR_TOP_SUMMARY, d);
            chk(d, 8'h00);
        end
    endtask : sc_summary

    // regulator flags: latch, summary chain, partial and full write-one clear
    task automatic sc_regulators();
        logic [7:0] d;
        logic [7:0] fa;
        for (int i = 0; i < 2; i++) begin
            fa = (i == 0) ? ADDR_REG12_FLAGS : ADDR_REG34_FLAGS;
            @(negedge clock);
            r_ev[i] = 8'h81;
            @(negedge clock);
            r_ev[i] = 8'h00;
            repeat (4) @(negedge clock);
            host_model.read_reg(fa, d);
            chk(d, 8'h81);
            host_model.read_reg(ADDR_GROUP_SUMMARY, d);
            chk(d, 8'h01 << i);
            host_model.read_reg(ADDR_TOP_SUMMARY, d);
            chk(d, 8'h01);
            host_model.write_reg(ADDR_TOP_SUMMARY, 8'hFF);
            host_model.write_reg(ADDR_GROUP_SUMMARY, 8'hFF);
            host_model.write_reg(fa, 8'h01);
            host_model.read_reg(ADDR_GROUP_SUMMARY, d);
            chk(d, 8'h01 << i);
            host_model.read_reg(fa, d);
            chk(d, 8'h80);
            host_model.write_reg(fa, 8'h80);
            repeat (3) @(negedge clock);
            chk({7'h00, interrupt_output_low_q}, 8'h01);
            host_model.read_reg(ADDR_TOP_SUMMARY, d);
            chk(d, 8'h00);
        end
    endtask : sc_regulators

    // ==========================================================
    // hang guard: the whole run is far shorter than this
    initial begin
        repeat (20000) @(posedge clock);
        error_cnt++;
        $display("BAD %0t run did not finish", $time);
        print_verdict();
    end

    // main sequence
    initial begin
        repeat (12) @(negedge clock);
        chk({7'h00, interrupt_output_low_q}, 8'h01);
        resetn = 1'b1;
        repeat (6) @(negedge clock);
        sc_registers();
        sc_events();
        sc_summary();
        sc_regulators();
        print_verdict();
    end
endmodule : testbench
